// File: ubc_map.svh
// Register offsets, field positions and reset values of the break comparator.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte offset.
`ifndef UBC_MAP_SVH
`define UBC_MAP_SVH

`define UBC_OFS_ADDR_HIGH 8'h00
`define UBC_OFS_ADDR_LOW 8'h04
`define UBC_OFS_MASK_HIGH 8'h08
`define UBC_OFS_MASK_LOW 8'h0c
`define UBC_OFS_COND_SEL 8'h10
`define UBC_OFS_IRQ_STATUS 8'h14
`define UBC_OFS_IRQ_CLEAR 8'h18
`define UBC_OFS_IRQ_ENABLE 8'h1c

`define UBC_RST_REG16 16'h0000
`define UBC_COND_MASK 16'h00ff
`define UBC_SRC_HI 7
`define UBC_SRC_LO 6
`define UBC_KIND_HI 5
`define UBC_KIND_LO 4
`define UBC_DIR_HI 3
`define UBC_DIR_LO 2
`define UBC_SIZE_HI 1
`define UBC_SIZE_LO 0
`define UBC_IRQ_BREAK_BIT 0

`endif

// File: ubc_pkg.sv
// Types shared by the break comparator.
// Assumes the register map header is included beside it.
package ubc_pkg;

	typedef enum logic [1:0] {
		UBC_SZ_ANY = 2'b00,
		UBC_SZ_BYTE = 2'b01,
		UBC_SZ_WORD = 2'b10,
		UBC_SZ_LONG = 2'b11
	} ubc_size_t;

	typedef enum logic [1:0] {
		UBC_BUS_IDLE = 2'b00,
		UBC_BUS_ANSWER = 2'b01
	} ubc_bus_state_t;

endpackage

// File: ubc_comparator.sv
// User break comparator: watches monitored bus cycles, raises an interrupt.
// Assumes one 40 MHz clock; monitored cycle inputs are synchronous strobes.
`timescale 1ns/1ps
`include "ubc_map.svh"

module ubc_comparator
	import ubc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Monitored bus cycle
	input wire logic mon_valid_i,
	input wire logic [31:0] mon_address_i,
	input wire logic mon_is_dma_i,
	input wire logic mon_is_data_i,
	input wire logic mon_is_write_i,
	input wire logic [1:0] mon_size_i,
	// Interrupt
	output logic break_irq_o
);

	logic [15:0] addr_high_reg;
	logic [15:0] addr_low_reg;
	logic [15:0] mask_high_reg;
	logic [15:0] mask_low_reg;
	logic [15:0] cond_sel_reg;
	logic status_reg;
	logic enable_reg;
	logic [31:0] readdata_reg;
	ubc_bus_state_t bus_state_reg;
	ubc_bus_state_t bus_state_next;

	// Bus slave: one wait cycle, answer on the second edge
	wire req = avs_read_i | avs_write_i;
	wire taken = req & (bus_state_reg == UBC_BUS_ANSWER);
	wire wr_taken = taken & avs_write_i;
	wire lo_lanes = avs_byteenable_i[0] | avs_byteenable_i[1];
	wire [15:0] be_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	wire [15:0] wdata_lo = avs_writedata_i[15:0];
	wire wr_addr_high = wr_taken & (avs_address_i == `UBC_OFS_ADDR_HIGH);
	wire wr_addr_low = wr_taken & (avs_address_i == `UBC_OFS_ADDR_LOW);
	wire wr_mask_high = wr_taken & (avs_address_i == `UBC_OFS_MASK_HIGH);
	wire wr_mask_low = wr_taken & (avs_address_i == `UBC_OFS_MASK_LOW);
	wire wr_cond = wr_taken & (avs_address_i == `UBC_OFS_COND_SEL);
	wire wr_clear = wr_taken & (avs_address_i == `UBC_OFS_IRQ_CLEAR)
		& avs_byteenable_i[0];
	wire wr_enable = wr_taken & (avs_address_i == `UBC_OFS_IRQ_ENABLE)
		& avs_byteenable_i[0];

	assign avs_waitrequest_o = req & (bus_state_reg != UBC_BUS_ANSWER);

	always_comb begin
		unique case (bus_state_reg)
			UBC_BUS_IDLE: bus_state_next = req ? UBC_BUS_ANSWER : UBC_BUS_IDLE;
			UBC_BUS_ANSWER: bus_state_next = UBC_BUS_IDLE;
			default: bus_state_next = UBC_BUS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			bus_state_reg <= UBC_BUS_IDLE;
		end else begin
			bus_state_reg <= bus_state_next;
		end
	end

	function automatic logic [15:0] merge(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [15:0] lanes);
		merge = (old_v & ~lanes) | (new_v & lanes);
	endfunction

	// Software registers, byte lanes honoured
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			addr_high_reg <= `UBC_RST_REG16;
			addr_low_reg <= `UBC_RST_REG16;
			mask_high_reg <= `UBC_RST_REG16;
			mask_low_reg <= `UBC_RST_REG16;
			cond_sel_reg <= `UBC_RST_REG16;
			enable_reg <= 1'b0;
		end else begin
			if (wr_addr_high & lo_lanes) begin
				addr_high_reg <= merge(addr_high_reg, wdata_lo, be_mask);
			end
			if (wr_addr_low & lo_lanes) begin
				addr_low_reg <= merge(addr_low_reg, wdata_lo, be_mask);
			end
			if (wr_mask_high & lo_lanes) begin
				mask_high_reg <= merge(mask_high_reg, wdata_lo, be_mask);
			end
			if (wr_mask_low & lo_lanes) begin
				mask_low_reg <= merge(mask_low_reg, wdata_lo, be_mask);
			end
			if (wr_cond & lo_lanes) begin
				// Upper byte is reserved and stays zero
				cond_sel_reg <= merge(cond_sel_reg, wdata_lo, be_mask)
					& `UBC_COND_MASK;
			end
			if (wr_enable) begin
				enable_reg <= avs_writedata_i[`UBC_IRQ_BREAK_BIT];
			end
		end
	end

	// Read mux; unmapped offsets answer zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address_i)
			`UBC_OFS_ADDR_HIGH: rd_mux = {16'h0000, addr_high_reg};
			`UBC_OFS_ADDR_LOW: rd_mux = {16'h0000, addr_low_reg};
			`UBC_OFS_MASK_HIGH: rd_mux = {16'h0000, mask_high_reg};
			`UBC_OFS_MASK_LOW: rd_mux = {16'h0000, mask_low_reg};
			`UBC_OFS_COND_SEL: rd_mux = {16'h0000, cond_sel_reg};
			`UBC_OFS_IRQ_STATUS: rd_mux = {31'h0000_0000, status_reg};
			`UBC_OFS_IRQ_ENABLE: rd_mux = {31'h0000_0000, enable_reg};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			readdata_reg <= 32'h0000_0000;
		end else if (req & (bus_state_reg == UBC_BUS_IDLE) & avs_read_i) begin
			readdata_reg <= rd_mux;
		end
	end
	assign avs_readdata_o = readdata_reg;

	// Address compare, one generate loop with one iteration per bit
	wire [31:0] brk_addr = {addr_high_reg, addr_low_reg};
	wire [31:0] brk_mask = {mask_high_reg, mask_low_reg};
	wire [31:0] bit_ok;
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_cmp
			assign bit_ok[gi] = brk_mask[gi] |
				(mon_address_i[gi] == brk_addr[gi]);
		end
	endgenerate
	wire addr_hit = &bit_ok;

	// Qualifiers; a 00 field in the first three disables the break
	wire [1:0] src_sel = cond_sel_reg[`UBC_SRC_HI:`UBC_SRC_LO];
	wire [1:0] kind_sel = cond_sel_reg[`UBC_KIND_HI:`UBC_KIND_LO];
	wire [1:0] dir_sel = cond_sel_reg[`UBC_DIR_HI:`UBC_DIR_LO];
	wire [1:0] size_sel = cond_sel_reg[`UBC_SIZE_HI:`UBC_SIZE_LO];
	wire src_ok = mon_is_dma_i ? src_sel[1] : src_sel[0];
	wire kind_ok = mon_is_data_i ? kind_sel[1] : kind_sel[0];
	wire dir_ok = mon_is_write_i ? dir_sel[1] : dir_sel[0];
	wire size_ok = (size_sel == UBC_SZ_ANY) | (size_sel == mon_size_i);
	wire break_hit = mon_valid_i & addr_hit & src_ok & kind_ok & dir_ok
		& size_ok;

	// Sticky status; a new hit wins over a clear in the same cycle
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			status_reg <= 1'b0;
		end else if (break_hit) begin
			status_reg <= 1'b1;
		end else if (wr_clear & avs_writedata_i[`UBC_IRQ_BREAK_BIT]) begin
			status_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			break_irq_o <= 1'b0;
		end else begin
			break_irq_o <= status_reg & enable_reg;
		end
	end

	// Checks
	a_hit_sets_status: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		break_hit |=> status_reg)
		else $error("break hit did not set status");
	a_no_source_none: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		(src_sel == 2'b00) |-> !break_hit)
		else $error("hit with source select zero");
	a_no_kind_none: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		(kind_sel == 2'b00) |-> !break_hit)
		else $error("hit with access kind zero");
	a_no_dir_none: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		(dir_sel == 2'b00) |-> !break_hit)
		else $error("hit with direction zero");
	a_size_filter: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		break_hit && size_sel != 2'b00 |-> mon_size_i == size_sel)
		else $error("hit with wrong size");
	a_unmasked_equal: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		break_hit |-> ((mon_address_i ^ brk_addr) & ~brk_mask) == 32'h0000_0000)
		else $error("hit with unmasked address mismatch");
	a_addr_high_write: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		wr_addr_high && avs_byteenable_i[1:0] == 2'b11
		|=> addr_high_reg == $past(avs_writedata_i[15:0]))
		else $error("address high not written");
	a_addr_low_write: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		wr_addr_low && avs_byteenable_i[1:0] == 2'b11
		|=> addr_low_reg == $past(avs_writedata_i[15:0]))
		else $error("address low not written");
	a_mask_high_write: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		wr_mask_high && avs_byteenable_i[1:0] == 2'b11
		|=> mask_high_reg == $past(avs_writedata_i[15:0]))
		else $error("mask high not written");
	a_mask_low_write: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		wr_mask_low && avs_byteenable_i[1:0] == 2'b11
		|=> mask_low_reg == $past(avs_writedata_i[15:0]))
		else $error("mask low not written");
	a_irq_follows: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		status_reg && enable_reg |=> break_irq_o)
		else $error("interrupt not raised");

	// Bus handshake: exactly one wait cycle per request
	a_wait_first: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		(req && bus_state_reg == UBC_BUS_IDLE) |-> avs_waitrequest_o)
		else $error("no wait in first request cycle");
	a_wait_answer: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		(req && bus_state_reg == UBC_BUS_ANSWER) |-> !avs_waitrequest_o)
		else $error("wait held in answer cycle");
	a_wait_no_req: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		!req |-> !avs_waitrequest_o)
		else $error("wait raised without request");
	a_wait_then_answer: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		avs_waitrequest_o |=> bus_state_reg == UBC_BUS_ANSWER)
		else $error("wait cycle not followed by answer");
	a_answer_once: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		bus_state_reg == UBC_BUS_ANSWER |=> bus_state_reg == UBC_BUS_IDLE)
		else $error("answer state held too long");
	a_read_loaded: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		(avs_read_i && avs_waitrequest_o)
		|=> avs_readdata_o == $past(rd_mux))
		else $error("read data not loaded in wait cycle");
	a_read_upper_zero: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		avs_readdata_o[31:16] == 16'h0000)
		else $error("read data upper half not zero");

	// Register writes
	a_cond_reserved: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		cond_sel_reg[15:8] == 8'h00)
		else $error("condition upper byte not zero");
	a_cond_write: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		wr_cond && avs_byteenable_i[1:0] == 2'b11
		|=> cond_sel_reg == {8'h00, $past(avs_writedata_i[7:0])})
		else $error("condition select not written");
	a_lane_keep: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		wr_addr_high && avs_byteenable_i[1:0] == 2'b01
		|=> addr_high_reg[15:8] == $past(addr_high_reg[15:8]))
		else $error("disabled byte lane was written");
	a_unmapped_write: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		(wr_taken && avs_address_i > `UBC_OFS_IRQ_ENABLE)
		|=> $stable(brk_addr) && $stable(brk_mask)
			&& $stable(cond_sel_reg) && $stable(enable_reg))
		else $error("unmapped write changed a register");
	a_enable_write: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		wr_enable |=> enable_reg == $past(avs_writedata_i[0]))
		else $error("interrupt enable not written");
	a_status_read_only: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		(wr_taken && avs_address_i == `UBC_OFS_IRQ_STATUS && !break_hit)
		|=> status_reg == $past(status_reg))
		else $error("status changed by a write");

	// Sticky status and level interrupt
	a_clear_status: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		(wr_clear && avs_writedata_i[0] && !break_hit) |=> !status_reg)
		else $error("clear did not drop status");
	a_status_sticky: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		(status_reg && !wr_clear) |=> status_reg)
		else $error("status dropped without clear");
	a_status_quiet: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		(!status_reg && !break_hit) |=> !status_reg)
		else $error("status set without a hit");
	a_irq_needs_enable: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		!enable_reg |=> !break_irq_o)
		else $error("interrupt raised while disabled");
	a_irq_needs_status: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		!status_reg |=> !break_irq_o)
		else $error("interrupt raised without status");
	a_irq_level: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		break_irq_o |-> $past(status_reg) && $past(enable_reg))
		else $error("interrupt not backed by status and enable");

	// Qualifiers, source, kind and direction fields indexed by the cycle's own attribute
	a_source_match: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		break_hit |-> src_sel[mon_is_dma_i])
		else $error("hit from an unselected source");
	a_kind_match: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		break_hit |-> kind_sel[mon_is_data_i])
		else $error("hit from an unselected access kind");
	a_dir_match: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		break_hit |-> dir_sel[mon_is_write_i])
		else $error("hit from an unselected direction");
	a_full_match: assert property (@(posedge core_clk_i)
		disable iff (reset_i)
		(mon_valid_i
			&& ((mon_address_i ^ brk_addr) & ~brk_mask) == 32'h0000_0000
			&& src_sel[mon_is_dma_i] && kind_sel[mon_is_data_i]
			&& dir_sel[mon_is_write_i]
			&& (size_sel == 2'b00 || size_sel == mon_size_i))
		|=> status_reg)
		else $error("matching cycle did not set status");

	c_break_hit: cover property (@(posedge core_clk_i) disable iff (reset_i)
		break_hit);
	c_dma_hit: cover property (@(posedge core_clk_i) disable iff (reset_i)
		break_hit && mon_is_dma_i);
	c_irq_clear: cover property (@(posedge core_clk_i) disable iff (reset_i)
		break_irq_o ##1 wr_clear ##2 !break_irq_o);
	c_masked_hit: cover property (@(posedge core_clk_i) disable iff (reset_i)
		break_hit && brk_mask != 32'h0000_0000);
	c_set_over_clear: cover property (@(posedge core_clk_i)
		disable iff (reset_i) break_hit && wr_clear);

endmodule

// File: ubc_bus_model.sv
// Model of the processor and DMA bus cycles seen by the break comparator.
// Assumes the bench calls issue between clock edges or right after one.
`timescale 1ns/1ps
module ubc_bus_model (
	// Clock
	input wire logic core_clk_i,
	// Monitored cycle
	output logic valid_o,
	output logic [31:0] address_o,
	output logic [4:0] qual_o
);
	initial begin
		{valid_o, address_o, qual_o} = '0;
	end
	// Qualifier order: dma, data, write, size[1:0]
	task issue(input logic [31:0] a, input logic [4:0] q);
		@(posedge core_clk_i);
		valid_o <= 1'b1;
		{address_o, qual_o} <= {a, q};
		@(posedge core_clk_i);
		valid_o <= 1'b0;
		// Idle lines mean nothing, so invert them rather than hold them
		{address_o, qual_o} <= ~{a, q};
	endtask
endmodule

// File: ubc_comparator_tb_top.sv
// Self-checking bench for the break comparator.
// Assumes the register map header and the bus model beside it.
`timescale 1ns/1ps
`include "ubc_map.svh"
module ubc_comparator_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic irq_en = 1'b0;
	logic [3:0] be = 4'hf;
	logic [7:0] adr = '0;
	logic [31:0] wd = '0;
	logic [31:0] rdata;
	wire [31:0] rdo;
	wire [31:0] ma;
	wire [4:0] mq;
	wire wt, irq, mv;
	int err_count = 0;
	int checked = 0;
	always #12.5 clk = ~clk;
	ubc_comparator i_ubc_comparator (.core_clk_i(clk), .reset_i(rst),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_byteenable_i(be),
		.avs_readdata_o(rdo), .avs_waitrequest_o(wt), .mon_valid_i(mv),
		.mon_address_i(ma), .mon_is_dma_i(mq[4]), .mon_is_data_i(mq[3]),
		.mon_is_write_i(mq[2]), .mon_size_i(mq[1:0]), .break_irq_o(irq));
	ubc_bus_model i_ubc_bus_model (.core_clk_i(clk), .valid_o(mv),
		.address_o(ma), .qual_o(mq));
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wt !== 1'b0 && n < 16);
		rdata = rdo;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 16) err_count++;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("readdata", e, rdata);
	endtask
	task hit(input logic [31:0] a, input logic [4:0] q, input logic e);
		i_ubc_bus_model.issue(a, q);
		repeat (2) @(posedge clk);
		chk("break_irq_o", {31'h0, e & irq_en}, {31'h0, irq});
		rchk(`UBC_OFS_IRQ_STATUS, {31'h0, e});
		bus(1'b1, `UBC_OFS_IRQ_CLEAR, 32'h1);
	endtask
	task t_regs;
		logic [15:0] p;
		for (int i = 0; i < 5; i++) begin
			p = 16'ha5c3 ^ 16'(i);
			rchk(8'(4 * i), 32'h0);
			bus(1'b1, 8'(4 * i), {16'hffff, p});
			rchk(8'(4 * i), i < 4 ? {16'h0, p} : {24'h0, p[7:0]});
		end
		rchk(`UBC_OFS_IRQ_CLEAR, 32'h0);
		rchk(8'h20, 32'h0);
		rchk(`UBC_OFS_IRQ_ENABLE, 32'h0);
		be <= 4'h1;
		bus(1'b1, `UBC_OFS_ADDR_HIGH, 32'h0);
		be <= 4'hf;
		rchk(`UBC_OFS_ADDR_HIGH, 32'h0000_a500);
		$display("test regs done");
	endtask
	task cfg(input logic [31:0] a, input logic [31:0] m);
		bus(1'b1, `UBC_OFS_ADDR_HIGH, {16'h0, a[31:16]});
		bus(1'b1, `UBC_OFS_ADDR_LOW, {16'h0, a[15:0]});
		bus(1'b1, `UBC_OFS_MASK_HIGH, {16'h0, m[31:16]});
		bus(1'b1, `UBC_OFS_MASK_LOW, {16'h0, m[15:0]});
		bus(1'b1, `UBC_OFS_COND_SEL, 32'hfc);
	endtask
	task t_mask;
		irq_en = 1'b1;
		bus(1'b1, `UBC_OFS_IRQ_ENABLE, 32'h1);
		rchk(`UBC_OFS_IRQ_ENABLE, 32'h1);
		cfg(32'h1234_5678, 32'h0);
		hit(32'h1234_5678, 5'b00010, 1'b1);
		hit(32'h9234_5678, 5'b00010, 1'b0);
		hit(32'h1234_5679, 5'b00010, 1'b0);
		cfg(32'h1234_5678, 32'h8000_0001);
		hit(32'h9234_5679, 5'b00010, 1'b1);
		hit(32'h5234_5678, 5'b00010, 1'b0);
		$display("test mask done");
	endtask
	task t_qual;
		int sh;
		for (int f = 0; f < 3; f++) for (int s = 0; s < 4; s++)
			for (int b = 0; b < 2; b++) begin
				sh = 6 - 2 * f;
				bus(1'b1, `UBC_OFS_COND_SEL,
					(32'hfc & ~(32'h3 << sh)) | (32'(s) << sh));
				hit(32'h1234_5678, 5'(b << (4 - f)) | 5'b00010,
					1'((s >> b) & 1));
			end
		for (int s = 0; s < 4; s++) for (int z = 1; z < 4; z++) begin
			bus(1'b1, `UBC_OFS_COND_SEL, 32'hfc | 32'(s));
			hit(32'h1234_5678, 5'(z), s == 0 || s == z);
		end
		$display("test qualifiers done");
	endtask
	task t_irq;
		irq_en = 1'b0;
		bus(1'b1, `UBC_OFS_IRQ_ENABLE, 32'h0);
		// Size select is left at longword by the qualifier test
		i_ubc_bus_model.issue(32'h1234_5678, 5'b00011);
		repeat (2) @(posedge clk);
		chk("break_irq_o", 32'h0, {31'h0, irq});
		bus(1'b1, `UBC_OFS_IRQ_STATUS, 32'h0);
		rchk(`UBC_OFS_IRQ_STATUS, 32'h1);
		bus(1'b1, `UBC_OFS_IRQ_ENABLE, 32'h1);
		repeat (2) @(posedge clk);
		chk("break_irq_o", 32'h1, {31'h0, irq});
		bus(1'b1, `UBC_OFS_IRQ_CLEAR, 32'h1);
		repeat (2) @(posedge clk);
		chk("break_irq_o", 32'h0, {31'h0, irq});
		$display("test interrupt done");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_mask();
		t_qual();
		t_irq();
		final_report();
	end
	// Whole run needs under a thousand cycles; this is a generous cap
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		final_report();
	end
endmodule
